// ---- urs_pkg.sv ----
// Purpose: Constants, rate table and state types of the channel
// Assumes: 8-bit registers in lane 0 at byte address 4 * index
// Notes:   Rate table values are in tenths of a bit per second so that 134.5 stays exact
package urs_pkg;

    localparam int          CLK_HZ        = 125_000_000;

    // Register indices
    localparam logic [3:0]  IDX_MODE      = 4'h0;
    localparam logic [3:0]  IDX_STAT_CSEL = 4'h1;
    localparam logic [3:0]  IDX_CMD       = 4'h2;
    localparam logic [3:0]  IDX_DATA      = 4'h3;
    localparam logic [3:0]  IDX_AUX       = 4'h4;
    localparam logic [3:0]  IDX_IRQ_STAT  = 4'h5;
    localparam logic [3:0]  IDX_IRQ_MASK  = 4'h6;
    localparam logic [3:0]  IDX_TEST      = 4'hA;

    // Values after reset
    localparam logic [7:0]  MODE_RST      = 8'h00;
    localparam logic [7:0]  CSEL_RST      = 8'h00;
    localparam logic [7:0]  AUX_RST       = 8'h00;
    localparam logic [2:0]  MASK_RST      = 3'h0;

    // Field positions and codes
    localparam int          MODE_PAR_LO   = 3;
    localparam logic [1:0]  WAKE_CODE     = 2'h3;
    localparam int          AUX_SET_BIT   = 7;
    localparam int          CSEL_RX_LO    = 4;
    localparam int          CSEL_TX_LO    = 0;
    localparam logic [3:0]  CODE_TIMER    = 4'hD;
    localparam logic [3:0]  CODE_EXT16    = 4'hE;
    localparam logic [3:0]  CODE_EXT1     = 4'hF;
    localparam int          IRQ_RX_READY  = 0;
    localparam int          IRQ_TX_FREE   = 1;
    localparam int          IRQ_RX_ERROR  = 2;

    // Command field codes
    localparam logic [1:0]  CMD_ENABLE    = 2'h1;
    localparam logic [1:0]  CMD_DISABLE   = 2'h2;
    localparam logic [2:0]  CMD_RESET_RX  = 3'h2;
    localparam logic [2:0]  CMD_RESET_TX  = 3'h3;

    // Sub-bit counts at 16x
    localparam logic [3:0]  SUB_LAST      = 4'hF;
    localparam logic [3:0]  RX_START_MID  = 4'h7;
    localparam logic [3:0]  TX_HOLDOFF    = 4'h3;
    localparam logic [2:0]  LAST_BIT      = 3'h7;
    localparam int          OVERSAMPLE    = 16;

    // Index is {test state, rate set, clock select code}; timer and external codes are unused here
    localparam int RATE10_TAB [0:63] = '{
        500,   1100, 1345,  2000,   3000,   6000,   12000,   10500,
        24000, 48000, 72000, 96000, 384000, 1,      1,       1,
        750,   1100, 1345,  1500,   3000,   6000,   12000,   20000,
        24000, 48000, 18000, 96000, 192000, 1,      1,       1,
        48000, 8800, 10760, 192000, 288000, 576000, 1152000, 10500,
        576000, 48000, 576000, 96000, 384000, 1,    1,       1,
        72000, 8800, 10760, 144000, 288000, 576000, 1152000, 20000,
        576000, 48000, 144000, 96000, 192000, 1,    1,       1
    };
    localparam int          DIV_MAX_BITS  = 18;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_WAIT  = 3'b001,
        TX_START = 3'b010,
        TX_DATA  = 3'b011,
        TX_STOP  = 3'b100
    } urs_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } urs_rx_state_t;

endpackage

// ---- urs_channel.sv ----
// Purpose: One serial channel with rate select and tx/rx control
// Assumes: One clock, synchronous active-high reset
// Notes:   8 data bits, one stop bit, no parity generation; parity-mode field only steers wake-up
//
// Notes on behaviour
// - Disabling right after a single load during underrun drops that character unsent.
// - Holding-free flag rises at the end of the start bit.
// - Holding register moves into the shift register as the start bit begins.
// - Empty flag reads set after underrun or right after enabling.
// - Rate comes from a table by select code, rate-set bit and test state.
// - Each read of index 2 toggles the rate-table test state.
// - Test state is shared by receiver and transmitter alike.
// - Test mode at index A forces 1x clocking and drives internal nodes out.
// - Receiver reset then enable restarts it; mode and rate programming stay.
// - In wake-up mode the receiver ignores disable and reset commands.
// - Disable within 3/16 bit (16x) or one bit (1x) of load sends nothing.
`timescale 1ns/1ps

module urs_channel
    import urs_pkg::*;
#(
    parameter int CNT_W = 20
)(
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [5:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    input  wire logic        timer_tick_in,
    input  wire logic        external_clock_input_in,
    input  wire logic        rx_line_in,
    output logic             tx_line_out,
    output logic             irq_out,
    output logic      [7:0]  test_port_out
);

    if (CNT_W < DIV_MAX_BITS)
    begin : g_chk
        $error("CNT_W too narrow for the slowest table rate");
    end

    function automatic logic [CNT_W-1:0] div_m1_f(input int i);
        longint v;
        v = (longint'(CLK_HZ) * 10) / (OVERSAMPLE * RATE10_TAB[i]) - 1;
        return v[CNT_W-1:0];
    endfunction

    logic             acc;
    logic             wr;
    logic             rd;
    logic [3:0]       idx;
    logic [7:0]       rd_mux;
    logic [7:0]       mode_config_one_q;
    logic [7:0]       clock_select_field_q;
    logic [7:0]       aux_q;
    logic [2:0]       mask_q;
    logic [2:0]       ist_q;
    logic [2:0]       ev;
    logic             rate_test_q;
    logic             test_mode_q;
    logic             cmd_wr;
    logic [1:0]       rx_cmd;
    logic [1:0]       tx_cmd;
    logic [2:0]       misc_cmd;
    logic [2:0]       ext_sync_q;
    logic             ext_lvl_q;
    logic             ext_rise;
    logic [2:0]       rx_sync_q;
    logic             rx_lvl_q;
    logic [1:0]       src_tick;
    logic [1:0]       one_x;
    logic [CNT_W-1:0] div_tab [64];

    assign acc      = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign wr       = acc & wb_we_in & wb_sel_in[0];
    assign rd       = acc & ~wb_we_in;
    assign idx      = wb_adr_in[5:2];
    assign cmd_wr   = wr && (idx == IDX_CMD);
    assign rx_cmd   = cmd_wr ? wb_dat_in[1:0] : 2'h0;
    assign tx_cmd   = cmd_wr ? wb_dat_in[3:2] : 2'h0;
    assign misc_cmd = cmd_wr ? wb_dat_in[6:4] : 3'h0;

    // One wait state per access
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_out <= acc;
            if (acc)
                wb_dat_out <= {24'h00_0000, rd_mux};
        end
    end

    // Software-written configuration
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            mode_config_one_q    <= MODE_RST;
            clock_select_field_q <= CSEL_RST;
            aux_q                <= AUX_RST;
            mask_q               <= MASK_RST;
            test_mode_q          <= 1'b0;
            rate_test_q          <= 1'b0;
        end
        else
        begin
            if (wr && idx == IDX_MODE)
                mode_config_one_q <= wb_dat_in[7:0];
            else if (wr && idx == IDX_STAT_CSEL)
                clock_select_field_q <= wb_dat_in[7:0];
            else if (wr && idx == IDX_AUX)
                aux_q <= wb_dat_in[7:0];
            else if (wr && idx == IDX_IRQ_MASK)
                mask_q <= wb_dat_in[2:0];
            else if (wr && idx == IDX_TEST)
                test_mode_q <= wb_dat_in[0];
            if (rd && idx == IDX_CMD)
                rate_test_q <= ~rate_test_q;
        end
    end

    // Pin inputs: three stages, a change is taken once the last two agree
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            ext_sync_q <= 3'h0;
            ext_lvl_q  <= 1'b0;
            rx_sync_q  <= 3'h7;
            rx_lvl_q   <= 1'b1;
        end
        else
        begin
            ext_sync_q <= {ext_sync_q[1:0], external_clock_input_in};
            rx_sync_q  <= {rx_sync_q[1:0], rx_line_in};
            if (ext_sync_q[1] == ext_sync_q[2])
                ext_lvl_q <= ext_sync_q[2];
            if (rx_sync_q[1] == rx_sync_q[2])
                rx_lvl_q <= rx_sync_q[2];
        end
    end

    assign ext_rise = (ext_sync_q[1] == ext_sync_q[2]) & ext_sync_q[2] & ~ext_lvl_q;

    for (genvar g = 0; g < 64; g++)
    begin : g_tab
        assign div_tab[g] = div_m1_f(g);
    end

    // Per direction rate source: 0 = receiver, 1 = transmitter
    for (genvar d = 0; d < 2; d++)
    begin : g_rate
        logic [3:0]       code;
        logic [CNT_W-1:0] div_m1;
        logic [CNT_W-1:0] cnt_q;
        logic             wrap;

        assign code   = clock_select_field_q[(d == 0 ? CSEL_RX_LO : CSEL_TX_LO) +: 4];
        // table lookup with shared test state
        assign div_m1 = div_tab[{rate_test_q, aux_q[AUX_SET_BIT], code}];
        assign wrap   = (cnt_q >= div_m1);

        always_ff @(posedge clock_in)
        begin
            if (rst_in || wrap)
                cnt_q <= '0;
            else
                cnt_q <= cnt_q + 1'b1;
        end

        assign src_tick[d] = (code == CODE_TIMER) ? timer_tick_in :
                             (code == CODE_EXT16 || code == CODE_EXT1) ? ext_rise : wrap;
        assign one_x[d]    = (code == CODE_EXT1) | test_mode_q;
    end

    // Transmitter
    urs_tx_state_t tx_state_q;
    logic [3:0]    tx_sub_q;
    logic [2:0]    tx_bit_q;
    logic [7:0]    tx_shift_q;
    logic [7:0]    thr_q;
    logic          thr_full_q;
    logic          tx_en_q;
    logic          tx_empty_flag_q;
    logic          tx_holding_free_flag;
    logic          tx_bit_end;
    logic          tx_hold_end;

    assign tx_holding_free_flag = tx_en_q & ~thr_full_q;
    assign tx_bit_end  = src_tick[1] & (one_x[1] | (tx_sub_q == SUB_LAST));
    assign tx_hold_end = src_tick[1] & (one_x[1] | (tx_sub_q == TX_HOLDOFF - 4'h1));

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            tx_state_q      <= TX_IDLE;
            tx_sub_q        <= 4'h0;
            tx_bit_q        <= 3'h0;
            tx_shift_q      <= 8'h00;
            thr_q           <= 8'h00;
            thr_full_q      <= 1'b0;
            tx_en_q         <= 1'b0;
            tx_empty_flag_q <= 1'b1;
            tx_line_out     <= 1'b1;
        end
        else
        begin
            if (src_tick[1])
                tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_cmd == CMD_ENABLE)
            begin
                tx_en_q         <= 1'b1;
                tx_empty_flag_q <= 1'b1;
            end
            else if (tx_cmd == CMD_DISABLE)
                tx_en_q <= 1'b0;
            if (wr && idx == IDX_DATA && tx_en_q && !thr_full_q)
            begin
                thr_q           <= wb_dat_in[7:0];
                thr_full_q      <= 1'b1;
                tx_empty_flag_q <= 1'b0;
            end
            case (tx_state_q)
                TX_IDLE:
                begin
                    tx_sub_q <= 4'h0;
                    if (tx_en_q && thr_full_q)
                        tx_state_q <= TX_WAIT;
                end
                TX_WAIT:
                begin
                    if (!tx_en_q)
                    begin
                        tx_state_q      <= TX_IDLE;
                        thr_full_q      <= 1'b0;
                        tx_empty_flag_q <= 1'b1;
                    end
                    else if (tx_hold_end)
                    begin
                        tx_shift_q  <= thr_q;
                        tx_line_out <= 1'b0;
                        tx_sub_q    <= 4'h0;
                        tx_state_q  <= TX_START;
                    end
                end
                TX_START:
                begin
                    if (tx_bit_end)
                    begin
                        thr_full_q  <= 1'b0;
                        tx_line_out <= tx_shift_q[0];
                        tx_bit_q    <= 3'h0;
                        tx_state_q  <= TX_DATA;
                    end
                end
                TX_DATA:
                begin
                    if (tx_bit_end)
                    begin
                        tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                        tx_bit_q   <= tx_bit_q + 3'h1;
                        if (tx_bit_q == LAST_BIT)
                        begin
                            tx_line_out <= 1'b1;
                            tx_state_q  <= TX_STOP;
                        end
                        else
                            tx_line_out <= tx_shift_q[1];
                    end
                end
                default:
                begin
                    if (tx_bit_end)
                    begin
                        // Back-to-back characters skip the load hold-off
                        if (tx_en_q && thr_full_q)
                        begin
                            tx_shift_q  <= thr_q;
                            tx_line_out <= 1'b0;
                            tx_state_q  <= TX_START;
                        end
                        else
                        begin
                            tx_empty_flag_q <= ~thr_full_q;
                            tx_state_q      <= TX_IDLE;
                        end
                    end
                end
            endcase
            if (misc_cmd == CMD_RESET_TX)
            begin
                tx_state_q      <= TX_IDLE;
                thr_full_q      <= 1'b0;
                tx_en_q         <= 1'b0;
                tx_empty_flag_q <= 1'b1;
                tx_line_out     <= 1'b1;
            end
        end
    end

    // Receiver
    urs_rx_state_t rx_state_q;
    logic [3:0]    rx_sub_q;
    logic [2:0]    rx_bit_q;
    logic [7:0]    rx_shift_q;
    logic [7:0]    rx_data_q;
    logic          rx_ready_q;
    logic          rx_overrun_q;
    logic          rx_framing_q;
    logic          rx_en_q;
    logic          rx_wake;
    logic          rx_run;
    logic          rx_sample;
    logic          rx_done;

    assign rx_wake   = (mode_config_one_q[MODE_PAR_LO +: 2] == WAKE_CODE);
    // wake-up keeps the receiver running even while disabled
    assign rx_run    = rx_en_q | rx_wake;
    assign rx_sample = src_tick[0] & (one_x[0] | (rx_sub_q == SUB_LAST));
    assign rx_done   = (rx_state_q == RX_STOP) & rx_sample;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            rx_state_q   <= RX_IDLE;
            rx_sub_q     <= 4'h0;
            rx_bit_q     <= 3'h0;
            rx_shift_q   <= 8'h00;
            rx_data_q    <= 8'h00;
            rx_ready_q   <= 1'b0;
            rx_overrun_q <= 1'b0;
            rx_framing_q <= 1'b0;
            rx_en_q      <= 1'b0;
        end
        else
        begin
            if (src_tick[0])
                rx_sub_q <= rx_sub_q + 4'h1;
            if (rd && idx == IDX_DATA)
                rx_ready_q <= 1'b0;
            case (rx_state_q)
                RX_IDLE:
                begin
                    rx_sub_q <= 4'h0;
                    rx_bit_q <= 3'h0;
                    if (rx_run && src_tick[0] && !rx_lvl_q)
                        rx_state_q <= one_x[0] ? RX_DATA : RX_START;
                end
                RX_START:
                begin
                    if (src_tick[0] && rx_sub_q == RX_START_MID)
                    begin
                        rx_sub_q   <= 4'h0;
                        rx_state_q <= rx_lvl_q ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA:
                begin
                    if (rx_sample)
                    begin
                        rx_shift_q <= {rx_lvl_q, rx_shift_q[7:1]};
                        rx_bit_q   <= rx_bit_q + 3'h1;
                        if (rx_bit_q == LAST_BIT)
                            rx_state_q <= RX_STOP;
                    end
                end
                default:
                begin
                    if (rx_sample)
                    begin
                        rx_data_q  <= rx_shift_q;
                        rx_ready_q <= 1'b1;
                        if (rx_ready_q)
                            rx_overrun_q <= 1'b1;
                        if (!rx_lvl_q)
                            rx_framing_q <= 1'b1;
                        rx_state_q <= RX_IDLE;
                    end
                end
            endcase
            if (!rx_run)
                rx_state_q <= RX_IDLE;
            if (rx_cmd == CMD_ENABLE)
                rx_en_q <= 1'b1;
            else if (rx_cmd == CMD_DISABLE && !rx_wake)
                rx_en_q <= 1'b0;
            if (misc_cmd == CMD_RESET_RX && !rx_wake)
            begin
                rx_en_q      <= 1'b0;
                rx_state_q   <= RX_IDLE;
                rx_ready_q   <= 1'b0;
                rx_overrun_q <= 1'b0;
                rx_framing_q <= 1'b0;
            end
        end
    end

    // Sticky interrupt status; a new event wins over a same-cycle clear
    assign ev[IRQ_RX_READY] = rx_done;
    assign ev[IRQ_TX_FREE]  = (tx_state_q == TX_START) & tx_bit_end;
    assign ev[IRQ_RX_ERROR] = rx_done & (rx_ready_q | ~rx_lvl_q);

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            ist_q         <= 3'h0;
            irq_out       <= 1'b0;
            test_port_out <= 8'h00;
        end
        else
        begin
            if (wr && idx == IDX_IRQ_STAT)
                ist_q <= (ist_q & ~wb_dat_in[2:0]) | ev;
            else
                ist_q <= ist_q | ev;
            irq_out <= |(ist_q & mask_q);
            test_port_out <= test_mode_q ? {rx_state_q, tx_state_q, src_tick, rate_test_q} : 8'h00;
        end
    end

    always_comb
    begin
        if (idx == IDX_MODE)
            rd_mux = mode_config_one_q;
        else if (idx == IDX_STAT_CSEL)
            rd_mux = {1'b0, rx_framing_q, 1'b0, rx_overrun_q,
                      tx_empty_flag_q, tx_holding_free_flag, 1'b0, rx_ready_q};
        else if (idx == IDX_DATA)
            rd_mux = rx_data_q;
        else if (idx == IDX_AUX)
            rd_mux = aux_q;
        else if (idx == IDX_IRQ_STAT)
            rd_mux = {5'h00, ist_q};
        else if (idx == IDX_IRQ_MASK)
            rd_mux = {5'h00, mask_q};
        else if (idx == IDX_TEST)
            rd_mux = {6'h00, rate_test_q, test_mode_q};
        else
            rd_mux = 8'h00;
    end

endmodule

// ---- urs_channel_assertions.sv ----
// Purpose: Bus and test-state checks at the channel ports
// Assumes: Single clock, synchronous active-high reset
// Notes:   Rate test state and test mode are tracked from bus traffic
`timescale 1ns/1ps

module urs_channel_assertions
    import urs_pkg::*;
(
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [5:0]  wb_adr_in,
    input wire logic [3:0]  wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic        wb_ack_out,
    input wire logic        tx_line_out,
    input wire logic        irq_out,
    input wire logic [7:0]  test_port_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    logic take, rate_q, tm_q;
    assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;

    always_ff @(posedge clock_in)
    begin
        rate_q <= rst_in ? 1'b0 : rate_q ^ (take && !wb_we_in && wb_adr_in[5:2] == IDX_CMD);
    end
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            tm_q <= 1'b0;
        else if (take && wb_we_in && wb_sel_in[0] && wb_adr_in[5:2] == IDX_TEST)
            tm_q <= wb_dat_in[0];
    end

    sequence s_rd(logic [3:0] idx);
        take && !wb_we_in && wb_adr_in[5:2] == idx;
    endsequence

    property p_ack_pulse;
        wb_ack_out |=> !wb_ack_out;
    endproperty
    property p_ack_answer;
        take |=> wb_ack_out;
    endproperty
    property p_ack_cause;
        wb_ack_out |-> $past(wb_cyc_in && wb_stb_in);
    endproperty
    property p_upper_zero;
        wb_ack_out |-> wb_dat_out[31:8] == 24'h00_0000;
    endproperty
    property p_cmd_read;
        s_rd(IDX_CMD) |=> wb_dat_out[7:0] == 8'h00;
    endproperty
    property p_rate_state;
        s_rd(IDX_TEST) |=> wb_dat_out[1] == rate_q && wb_dat_out[0] == tm_q;
    endproperty
    property p_port_idle;
        !tm_q && !$past(tm_q) |-> test_port_out == 8'h00;
    endproperty
    property p_port_rate;
        tm_q && $past(tm_q) && rate_q == $past(rate_q) |=> test_port_out[0] == $past(rate_q);
    endproperty
    property p_reset_idle;
        $past(rst_in) |-> tx_line_out && !irq_out;
    endproperty

    a_ack_pulse:
        assert property (p_ack_pulse) else $error("ack too long");
    a_ack_answer:
        assert property (p_ack_answer) else $error("no ack");
    a_ack_cause:
        assert property (p_ack_cause) else $error("stray ack");
    a_upper_zero:
        assert property (p_upper_zero) else $error("upper data set");
    a_cmd_read:
        assert property (p_cmd_read) else $error("cmd read set");
    a_rate_state:
        assert property (p_rate_state) else $error("test reg wrong");
    a_port_idle:
        assert property (p_port_idle) else $error("port active");
    a_port_rate:
        assert property (p_port_rate) else $error("port rate wrong");
    a_reset_idle:
        assert property (p_reset_idle) else $error("not idle");
endmodule

bind urs_channel urs_channel_assertions i_chk (.*);

// ---- urs_peer.sv ----
// Purpose: Remote serial peer, 8N1 LSB first
// Assumes: Bit period given in clocks by the bench
// Notes:   Samples mid-bit, so small rate errors are tolerated
`timescale 1ns/1ps

module urs_peer (
    input  wire logic        clock_in,
    input  wire logic [15:0] bit_clks_in,
    input  wire logic        line_in,
    output logic             line_out
);
    initial line_out = 1'b1;

    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clock_in);
            line_out <= f[i];
            repeat (bit_clks_in - 1) @(posedge clock_in);
        end
    endtask

    task automatic receive(output logic [7:0] b);
        @(posedge clock_in iff line_in === 1'b0);
        repeat (bit_clks_in / 2) @(posedge clock_in);
        for (int i = 0; i < 8; i++)
        begin
            repeat (bit_clks_in) @(posedge clock_in);
            b[i] = line_in;
        end
        repeat (bit_clks_in) @(posedge clock_in);
    endtask
endmodule

// ---- test_urs_channel.sv ----
// Purpose: Register-level tests of the channel against a serial peer
// Assumes: Timer code used for quick 16x ticks, one tick every 4 clocks
// Notes:   External clock input stays low; its codes are not exercised
`timescale 1ns/1ps

module test_urs_channel
    import urs_pkg::*;
;
    logic        clock_in, rst_in, cyc, stb, we, tick, tx, rx, irq, ack, quiet, ext;
    logic [3:0]  sel;
    logic [5:0]  adr;
    logic [31:0] wdat, rdat;
    logic [7:0]  tport, q, b;
    logic [15:0] bclk;
    logic [1:0]  tcnt;
    int          num_errors, n_tests, cycles;

    urs_channel i_dut (.clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .timer_tick_in(tick), .external_clock_input_in(ext), .rx_line_in(rx), .tx_line_out(tx),
        .irq_out(irq), .test_port_out(tport));
    urs_peer i_peer (.clock_in(clock_in), .bit_clks_in(bclk), .line_in(tx), .line_out(rx));

    initial
    begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    // Timer tick every 4 clocks gives a 64-clock bit
    always @(posedge clock_in)
    begin
        tcnt <= tcnt + 2'd1;
        tick <= (tcnt == 2'd3);
        cycles++;
        if (cycles == 50000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
        @(posedge clock_in);
        {cyc, stb, we, sel} <= {2'b11, w, 4'hF};
        adr  <= {i, 2'b00};
        wdat <= {24'h00_0000, d};
        do @(posedge clock_in); while (ack !== 1'b1);
        q = rdat[7:0];
        {cyc, stb} <= 2'b00;
    endtask

    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        bus(1'b1, i, d);
    endtask

    task automatic rd(input logic [3:0] i);
        bus(1'b0, i, 8'h00);
    endtask

    initial
    begin
        {rst_in, cyc, stb, we, tick, ext, sel, tcnt, adr, wdat, cycles} = '0;
        {num_errors, n_tests, bclk} = {32'd0, 32'd0, 16'd64};
        rst_in = 1'b1;
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        rd(IDX_TEST); chk("test reg", 8'h00, q);
        wr(IDX_MODE, 8'h10); wr(IDX_STAT_CSEL, 8'hDD); wr(IDX_IRQ_MASK, 8'h02); wr(IDX_CMD, 8'h05);
        rd(IDX_STAT_CSEL); chk("empty", 8'h08, q & 8'h08);
        wr(IDX_IRQ_STAT, 8'h07);
        wr(IDX_DATA, 8'hA5);
        fork
            i_peer.receive(b);
            begin
                @(posedge clock_in iff tx === 1'b0);
                repeat (32) @(posedge clock_in);
                rd(IDX_STAT_CSEL); chk("free in start", 8'h00, q & 8'h04);
                chk("irq in start", 8'h00, 8'(irq));
                repeat (64) @(posedge clock_in);
                rd(IDX_STAT_CSEL); chk("free after start", 8'h04, q & 8'h04);
                chk("irq free", 8'h01, 8'(irq));
                wr(IDX_CMD, 8'h08);
            end
        join
        chk("tx char", 8'hA5, b);
        wr(IDX_IRQ_STAT, 8'h02); repeat (2) @(posedge clock_in); chk("irq clear", 8'h00, 8'(irq));
        repeat (64) @(posedge clock_in);
        wr(IDX_CMD, 8'h04); rd(IDX_STAT_CSEL); chk("empty enabled", 8'h08, q & 8'h08);
        // Disable lands inside the 3-tick hold-off
        wr(IDX_DATA, 8'h3C); wr(IDX_CMD, 8'h08);
        quiet = 1'b0;
        repeat (768)
        begin
            @(posedge clock_in);
            quiet |= (tx !== 1'b1);
        end
        chk("tx dropped", 8'h00, 8'(quiet));
        rd(IDX_STAT_CSEL); chk("empty drop", 8'h08, q & 8'h08);
        i_peer.send(8'h96); repeat (8) @(posedge clock_in);
        chk("irq masked", 8'h00, 8'(irq));
        wr(IDX_IRQ_MASK, 8'h03); repeat (2) @(posedge clock_in); chk("irq rx", 8'h01, 8'(irq));
        rd(IDX_STAT_CSEL); chk("rx ready", 8'h01, q & 8'h01);
        rd(IDX_DATA); chk("rx char", 8'h96, q);
        wr(IDX_CMD, 8'h20); wr(IDX_CMD, 8'h01); i_peer.send(8'h69); repeat (8) @(posedge clock_in);
        rd(IDX_DATA); chk("rx after reset", 8'h69, q);
        rd(IDX_MODE); chk("mode kept", 8'h10, q);
        wr(IDX_MODE, 8'h18); wr(IDX_CMD, 8'h02); wr(IDX_CMD, 8'h20);
        i_peer.send(8'hC3); repeat (8) @(posedge clock_in);
        rd(IDX_DATA); chk("rx wake", 8'hC3, q);
        wr(IDX_MODE, 8'h10); wr(IDX_CMD, 8'h20); wr(IDX_MODE, 8'h18);
        i_peer.send(8'h0F); repeat (8) @(posedge clock_in);
        rd(IDX_DATA); chk("rx wake reset", 8'h0F, q);
        rd(IDX_CMD); chk("cmd read", 8'h00, q);
        rd(IDX_TEST); chk("rate test on", 8'h02, q);
        wr(IDX_STAT_CSEL, 8'h66); wr(IDX_CMD, 8'h04);
        bclk <= 16'(16 * (1250000000 / (16 * 1152000)));
        wr(IDX_DATA, 8'hE1); i_peer.receive(b); chk("tx ext rate", 8'hE1, b);
        i_peer.send(8'h1E); repeat (8) @(posedge clock_in);
        rd(IDX_DATA); chk("rx ext rate", 8'h1E, q);
        wr(IDX_TEST, 8'h01); rd(IDX_TEST); chk("test mode", 8'h03, q);
        chk("port rate", 8'h01, 8'(tport[0]));
        rst_in <= 1'b1; repeat (2) @(posedge clock_in); rst_in <= 1'b0;
        rd(IDX_TEST); chk("test after reset", 8'h00, q);
        rd(4'hC); chk("unmapped", 8'h00, q);
        report_and_stop();
    end
endmodule
